// ---- gccr_pkg.sv ----
// Constants, register map and field layouts of the config registers
package gccr_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_ID_AND_COMMAND = 8'h00;
	localparam logic [7:0] IDX_GENERAL_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_ID_AND_COMMAND = 8'(IDX_ID_AND_COMMAND * 4);
	localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'(IDX_GENERAL_CONFIG * 4);
	localparam logic [7:0] ADDR_TIMER = 8'h10;
	localparam logic [7:0] ADDR_STAMP = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_SBW_MASK = 8'h1c;

	// Command bit positions
	localparam int CMD_TOKEN_LAUNCH = 0;
	localparam int CMD_WATCHDOG_RESTART = 1;
	localparam int CMD_SOFT_RESET = 2;

	// Status bit positions
	localparam int ST_WD_ALARM = 0;
	localparam int ST_CLOCK_LOST = 1;
	localparam int ST_TOKEN_HELD = 2;
	localparam int ST_SECOND_SYNC = 3;

	// Identification fields, values arbitrary
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [3:0] ID_REVISION = 4'h2;
	localparam logic [3:0] ID_FOUNDRY = 4'h3;
	localparam logic [3:0] ID_TYPE = 4'h4;

	localparam logic [15:0] GCR_RESET = 16'h0000;
	localparam logic [15:0] TIMER_RESET = 16'h0010;
	localparam logic [15:0] SBW_MASK_RESET = 16'h0000;

	// Timing
	localparam longint CLK_HZ = 250000000;
	localparam longint QUARTER_MS = 250;
	localparam longint QUARTER_CYCLES = QUARTER_MS * CLK_HZ / 1000;
	localparam longint DATA_CLOCK_OUT_FAST_KHZ = 4096;
	localparam longint DATA_CLOCK_OUT_SLOW_KHZ = 2048;
	localparam logic [31:0] DATA_CLOCK_OUT_INC_FAST = 32'((DATA_CLOCK_OUT_FAST_KHZ * 1000 * 64'h100000000) / CLK_HZ);
	localparam logic [31:0] DATA_CLOCK_OUT_INC_SLOW = 32'((DATA_CLOCK_OUT_SLOW_KHZ * 1000 * 64'h100000000) / CLK_HZ);
	localparam logic [5:0] VCXO_DIV_SET = 6'h20;
	localparam logic [5:0] VCXO_DIV_CLR = 6'h1e;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int SBW_CHANNELS = 16;

	typedef enum logic [1:0] {
		SYNC_SY,
		SYNC_GCI,
		SYNC_VSTAR,
		SYNC_UNUSED
	} gccr_sync_t;

	// General configuration word, bit 15 first
	typedef struct packed {
		logic six_bit_word_enable;
		logic mem_bus_drive_idle;
		logic frame_half_bit_advance;
		logic single_clock;
		logic second_sync_active;
		logic select_second_sync;
		logic clock_supervision_off;
		logic high_bit_clock_sel;
		gccr_sync_t sync_format_sel;
		logic tx_hdlc_to_matrix_seven;
		logic ext_vcxo_divide_sel;
		logic time_stamp_enable;
		logic token_ring_disable;
		logic priority_mem_hold;
		logic watchdog_disable;
	} gccr_cfg_t;

	// Six-bit word report toward shared memory
	typedef struct packed {
		logic valid;
		logic [3:0] channel;
		logic [5:0] word;
	} gccr_sbw_t;

endpackage : gccr_pkg

// ---- gccr_top.sv ----
// Global identification, command and configuration registers with AXI4-Lite access
// Behaviour
// - Id read returns version, revision, foundry, type; reset leaves it.
// - Writing command bit 0 launches a token pulse on the token output.
// - Writing command bit 1 clears the watchdog counter.
// - Writing command bit 2 resets the device like the reset pin, except the bus handshake.
// - The three command bits are self-clearing pulses after each write.
// - Watchdog alarm stays low when disabled, else rises on timer expiry.
// - Priority hold set: an arriving token is captured and kept.
// - Priority hold clear: one memory access per token, then pass it on.
// - Token ring disabled: tokens destroyed, nothing emitted, no memory access.
// - Stamp enabled: binary down-counter 65535 to 0, one step each 250ms.
// - Stamp disabled: decimal counter forms the watchdog with the timer register.
// - VCXO divider ratio is 32 when set, 30 when clear.
// - Matrix input seven takes transmit HDLC when set, serial pin otherwise.
// - Two format bits select SY, GCI, V-star or unused frame sync.
// - High bit clock bit says incoming clock is 8192kHz or 4096kHz.
// - Supervision on: clock-loss pin rises 250ms after clock loss; else masked.
// - Host requests clock pair by select bit; read-only bit shows actual pair.
// - Single clock bit sets data clock output to 2048kHz or 4096kHz.
// - Frame advance bit shifts both frame syncs by half a bit.
// - Memory bus drive bit keeps bus driven between cycles, else released.
// - Six-bit word stored, interrupt raised, when received twice alike.
//
// The AXI4-Lite slave port was left to the implementer.

module gccr_pin_sync (
	input wire logic aclk,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic s1_reg, s2_reg, s3_reg;

	always_ff @(posedge aclk) begin
		s1_reg <= pin;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// Change taken only once two stages agree, rejects single-cycle glitches
	always_ff @(posedge aclk) begin
		if (rst) begin
			level <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end
endmodule : gccr_pin_sync

module gccr_top #(
	parameter longint QUARTER_SEC_CYCLES = gccr_pkg::QUARTER_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic token_in_pin,
	output logic token_out_pin,
	input wire logic mem_access_req,
	input wire logic mem_access_done,
	output logic mem_grant,
	input wire logic mem_cycle_active,
	output logic mem_bus_oe_n,
	output logic watchdog_alarm_out,
	input wire logic clock_a_pin,
	input wire logic clock_b_pin,
	output logic clock_loss_irq,
	output logic data_clock_out,
	input wire logic vcxo_ref_tick,
	output logic vcxo_sync_pulse,
	input wire logic tx_hdlc_bit,
	input wire logic serial_input_seven,
	output logic matrix_in_seven,
	input wire logic [5:0] sbw_word_in,
	input wire logic [3:0] sbw_chan_in,
	input wire logic sbw_valid_in,
	output gccr_pkg::gccr_sbw_t sbw_store,
	output logic sbw_irq,
	output gccr_pkg::gccr_cfg_t cfg_out,
	output logic device_reset_out
);
	localparam logic [31:0] QCYC = 32'(QUARTER_SEC_CYCLES - 1);

	logic rst;
	logic soft_reset_reg;
	gccr_pkg::gccr_cfg_t cfg_reg;
	logic [15:0] timer_reg;
	logic [15:0] sbw_mask_reg;
	logic [2:0] cmd_pulse_reg;
	logic [15:0] stamp_reg;
	logic [31:0] quarter_cnt_reg;
	logic quarter_tick;
	logic wd_alarm_reg;
	logic token_held_reg;
	logic token_lvl, token_lvl_d_reg, token_arrive;
	logic clk_a_lvl, clk_b_lvl, serial7_lvl;
	logic sel_lvl, sel_lvl_d_reg;
	logic [31:0] loss_cnt_reg;
	logic clock_lost_reg;
	logic second_active_reg;
	logic [31:0] data_clock_out_acc_reg;
	logic [5:0] vcxo_cnt_reg;
	logic [5:0] sbw_last [gccr_pkg::SBW_CHANNELS];
	logic [gccr_pkg::SBW_CHANNELS-1:0] sbw_seen_reg, sbw_stored_reg;
	logic aw_got_reg, w_got_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic [15:0] id_code;

	// Soft reset acts on everything but the bus handshake, so its write still completes
	assign rst = !aresetn || soft_reset_reg;
	assign device_reset_out = rst;
	assign id_code = {gccr_pkg::ID_TYPE, gccr_pkg::ID_FOUNDRY,
		gccr_pkg::ID_REVISION, gccr_pkg::ID_VERSION};

	// Write channel: address and data in either order, response after both
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gccr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_reg)
					gccr_pkg::ADDR_ID_AND_COMMAND, gccr_pkg::ADDR_GENERAL_CONFIG,
					gccr_pkg::ADDR_TIMER, gccr_pkg::ADDR_STAMP,
					gccr_pkg::ADDR_STATUS, gccr_pkg::ADDR_SBW_MASK: begin
						s_axi_bresp <= gccr_pkg::RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= gccr_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Command bits live one cycle only and never read back
	always_ff @(posedge aclk) begin
		if (rst) begin
			cmd_pulse_reg <= 3'h0;
		end else if (wr_fire && aw_addr_reg == gccr_pkg::ADDR_ID_AND_COMMAND && w_strb_reg[0]) begin
			cmd_pulse_reg <= w_data_reg[2:0];
		end else begin
			cmd_pulse_reg <= 3'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= cmd_pulse_reg[gccr_pkg::CMD_SOFT_RESET];
		end
	end

	// Configuration and own registers
	always_ff @(posedge aclk) begin
		if (rst) begin
			cfg_reg <= gccr_pkg::GCR_RESET;
			timer_reg <= gccr_pkg::TIMER_RESET;
			sbw_mask_reg <= gccr_pkg::SBW_MASK_RESET;
		end else if (wr_fire) begin
			case (aw_addr_reg)
				gccr_pkg::ADDR_GENERAL_CONFIG: begin
					if (w_strb_reg[0]) cfg_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) cfg_reg[15:8] <= w_data_reg[15:8];
				end
				gccr_pkg::ADDR_TIMER: begin
					if (w_strb_reg[0]) timer_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) timer_reg[15:8] <= w_data_reg[15:8];
				end
				gccr_pkg::ADDR_SBW_MASK: begin
					if (w_strb_reg[0]) sbw_mask_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) sbw_mask_reg[15:8] <= w_data_reg[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel, one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= gccr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= gccr_pkg::RESP_OKAY;
			case (s_axi_araddr)
				gccr_pkg::ADDR_ID_AND_COMMAND: s_axi_rdata <= {16'h0000, id_code};
				gccr_pkg::ADDR_GENERAL_CONFIG: s_axi_rdata <= {16'h0000, cfg_out};
				gccr_pkg::ADDR_TIMER: s_axi_rdata <= {16'h0000, timer_reg};
				gccr_pkg::ADDR_STAMP: s_axi_rdata <= {16'h0000, stamp_reg};
				gccr_pkg::ADDR_STATUS: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rdata[gccr_pkg::ST_WD_ALARM] <= wd_alarm_reg;
					s_axi_rdata[gccr_pkg::ST_CLOCK_LOST] <= clock_lost_reg;
					s_axi_rdata[gccr_pkg::ST_TOKEN_HELD] <= token_held_reg;
					s_axi_rdata[gccr_pkg::ST_SECOND_SYNC] <= second_active_reg;
				end
				gccr_pkg::ADDR_SBW_MASK: s_axi_rdata <= {16'h0000, sbw_mask_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= gccr_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Configuration outputs; the read-only field shows the pair actually in use
	always_comb begin
		cfg_out = cfg_reg;
		cfg_out.second_sync_active = second_active_reg;
	end

	// Quarter-second time base
	always_ff @(posedge aclk) begin
		if (rst || quarter_cnt_reg == QCYC) begin
			quarter_cnt_reg <= 32'h00000000;
		end else begin
			quarter_cnt_reg <= quarter_cnt_reg + 32'h00000001;
		end
	end
	assign quarter_tick = (quarter_cnt_reg == QCYC);

	// Decimal increment of four digits
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic carry;
		r = v;
		carry = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (carry) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_inc

	// Stamp counter, binary down or decimal watchdog count
	always_ff @(posedge aclk) begin
		if (rst) begin
			stamp_reg <= 16'h0000;
		end else if (cfg_reg.time_stamp_enable) begin
			if (quarter_tick) begin
				stamp_reg <= stamp_reg - 16'h0001;
			end
		end else if (cmd_pulse_reg[gccr_pkg::CMD_WATCHDOG_RESTART]) begin
			stamp_reg <= 16'h0000;
		end else if (quarter_tick && stamp_reg != timer_reg) begin
			stamp_reg <= bcd_inc(stamp_reg);
		end
	end

	// Alarm holds once set; a restart loses to the still-equal count and clears it only when the count differs; disable, stamp mode or reset clear it
	always_ff @(posedge aclk) begin
		if (rst || cfg_reg.watchdog_disable || cfg_reg.time_stamp_enable) begin
			wd_alarm_reg <= 1'b0;
		end else if (stamp_reg == timer_reg) begin
			wd_alarm_reg <= 1'b1;
		end else if (cmd_pulse_reg[gccr_pkg::CMD_WATCHDOG_RESTART]) begin
			wd_alarm_reg <= 1'b0;
		end
	end
	assign watchdog_alarm_out = wd_alarm_reg;

	// Pin inputs
	gccr_pin_sync u_sync_token (.aclk(aclk), .rst(rst), .pin(token_in_pin), .level(token_lvl));
	gccr_pin_sync u_sync_clka (.aclk(aclk), .rst(rst), .pin(clock_a_pin), .level(clk_a_lvl));
	gccr_pin_sync u_sync_clkb (.aclk(aclk), .rst(rst), .pin(clock_b_pin), .level(clk_b_lvl));
	gccr_pin_sync u_sync_serial_input_seven (.aclk(aclk), .rst(rst), .pin(serial_input_seven),
		.level(serial7_lvl));

	always_ff @(posedge aclk) begin
		if (rst) begin
			token_lvl_d_reg <= 1'b0;
		end else begin
			token_lvl_d_reg <= token_lvl;
		end
	end
	assign token_arrive = token_lvl && !token_lvl_d_reg;

	// Token ring: hold, pass after one access, or destroy when disabled
	always_ff @(posedge aclk) begin
		if (rst) begin
			token_held_reg <= 1'b0;
			token_out_pin <= 1'b0;
		end else begin
			token_out_pin <= 1'b0;
			if (cfg_reg.token_ring_disable) begin
				token_held_reg <= 1'b0;
			end else if (cmd_pulse_reg[gccr_pkg::CMD_TOKEN_LAUNCH]) begin
				token_out_pin <= 1'b1;
			end else if (token_arrive) begin
				token_held_reg <= 1'b1;
			end else if (token_held_reg && !cfg_reg.priority_mem_hold && mem_access_done) begin
				token_held_reg <= 1'b0;
				token_out_pin <= 1'b1;
			end
		end
	end

	// Access only with token and ring enabled
	assign mem_grant = token_held_reg && mem_access_req && !cfg_reg.token_ring_disable;

	// Low enable drives the bus
	always_ff @(posedge aclk) begin
		if (rst) begin
			mem_bus_oe_n <= 1'b1;
		end else begin
			mem_bus_oe_n <= !(mem_cycle_active || cfg_reg.mem_bus_drive_idle);
		end
	end

	// Clock supervision on the selected pair
	assign sel_lvl = second_active_reg ? clk_b_lvl : clk_a_lvl;

	always_ff @(posedge aclk) begin
		if (rst) begin
			sel_lvl_d_reg <= 1'b0;
			loss_cnt_reg <= 32'h00000000;
			clock_lost_reg <= 1'b0;
		end else begin
			sel_lvl_d_reg <= sel_lvl;
			if (sel_lvl != sel_lvl_d_reg) begin
				loss_cnt_reg <= 32'h00000000;
				clock_lost_reg <= 1'b0;
			end else if (loss_cnt_reg == QCYC) begin
				clock_lost_reg <= 1'b1;
			end else begin
				loss_cnt_reg <= loss_cnt_reg + 32'h00000001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			clock_loss_irq <= 1'b0;
		end else begin
			clock_loss_irq <= clock_lost_reg && !cfg_reg.clock_supervision_off;
		end
	end

	// Pair switch follows the request one cycle later
	always_ff @(posedge aclk) begin
		if (rst) begin
			second_active_reg <= 1'b0;
		end else begin
			second_active_reg <= cfg_reg.select_second_sync;
		end
	end

	// Data clock from a phase accumulator; 250MHz has no integer ratio to it
	always_ff @(posedge aclk) begin
		if (rst) begin
			data_clock_out_acc_reg <= 32'h00000000;
		end else begin
			data_clock_out_acc_reg <= data_clock_out_acc_reg + (cfg_reg.single_clock ?
				gccr_pkg::DATA_CLOCK_OUT_INC_SLOW : gccr_pkg::DATA_CLOCK_OUT_INC_FAST);
		end
	end
	assign data_clock_out = data_clock_out_acc_reg[31];

	// VCXO synchronisation divider
	always_ff @(posedge aclk) begin
		if (rst) begin
			vcxo_cnt_reg <= 6'h00;
			vcxo_sync_pulse <= 1'b0;
		end else begin
			vcxo_sync_pulse <= 1'b0;
			if (vcxo_ref_tick) begin
				if (vcxo_cnt_reg >= (cfg_reg.ext_vcxo_divide_sel ?
					gccr_pkg::VCXO_DIV_SET : gccr_pkg::VCXO_DIV_CLR) - 6'h01) begin
					vcxo_cnt_reg <= 6'h00;
					vcxo_sync_pulse <= 1'b1;
				end else begin
					vcxo_cnt_reg <= vcxo_cnt_reg + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			matrix_in_seven <= 1'b0;
		end else begin
			matrix_in_seven <= cfg_reg.tx_hdlc_to_matrix_seven ? tx_hdlc_bit : serial7_lvl;
		end
	end

	// Six-bit word: stored once per new word seen twice in a row
	always_ff @(posedge aclk) begin
		if (rst) begin
			sbw_seen_reg <= '0;
			sbw_stored_reg <= '0;
			sbw_store <= '0;
			sbw_irq <= 1'b0;
			for (int i = 0; i < gccr_pkg::SBW_CHANNELS; i++) begin
				sbw_last[i] <= 6'h00;
			end
		end else begin
			sbw_store.valid <= 1'b0;
			sbw_irq <= 1'b0;
			if (!cfg_reg.six_bit_word_enable) begin
				sbw_seen_reg <= '0;
				sbw_stored_reg <= '0;
			end else if (sbw_valid_in) begin
				sbw_last[sbw_chan_in] <= sbw_word_in;
				sbw_seen_reg[sbw_chan_in] <= 1'b1;
				if (sbw_seen_reg[sbw_chan_in] && sbw_last[sbw_chan_in] == sbw_word_in) begin
					if (!sbw_stored_reg[sbw_chan_in]) begin
						sbw_stored_reg[sbw_chan_in] <= 1'b1;
						sbw_store.valid <= 1'b1;
						sbw_store.channel <= sbw_chan_in;
						sbw_store.word <= sbw_word_in;
						sbw_irq <= !sbw_mask_reg[sbw_chan_in];
					end
				end else begin
					sbw_stored_reg[sbw_chan_in] <= 1'b0;
				end
			end
		end
	end

endmodule : gccr_top

// ---- gccr_top_sva.sv ----
// Assertion checker for the config registers
module gccr_top_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic token_out_pin,
	input wire logic mem_access_req,
	input wire logic mem_grant,
	input wire logic mem_cycle_active,
	input wire logic mem_bus_oe_n,
	input wire logic watchdog_alarm_out,
	input wire logic clock_loss_irq,
	input wire logic [5:0] sbw_word_in,
	input wire logic [3:0] sbw_chan_in,
	input wire logic sbw_valid_in,
	input wire gccr_pkg::gccr_sbw_t sbw_store,
	input wire gccr_pkg::gccr_cfg_t cfg_out,
	input wire logic device_reset_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence id_req;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == gccr_pkg::ADDR_ID_AND_COMMAND;
	endsequence
	// Select must sit still two cycles before the status bit must match it
	sequence sel_steady;
		$stable(cfg_out.select_second_sync) [*2];
	endsequence

	chk_id_read:
		assert property (id_req |=> s_axi_rvalid && s_axi_rdata == {16'h0000, gccr_pkg::ID_TYPE,
			gccr_pkg::ID_FOUNDRY, gccr_pkg::ID_REVISION, gccr_pkg::ID_VERSION})
		else $error("bad id word");
	chk_tok_single:
		assert property (token_out_pin |=> !token_out_pin)
		else $error("long token pulse");
	chk_soft_pulse:
		assert property (device_reset_out |=> !device_reset_out)
		else $error("soft reset stuck");
	chk_wd_masked:
		assert property (cfg_out.watchdog_disable && $past(cfg_out.watchdog_disable)
			|-> !watchdog_alarm_out)
		else $error("alarm while disabled");
	chk_grant_cause:
		assert property (mem_grant |-> mem_access_req && !cfg_out.token_ring_disable)
		else $error("bad grant");
	chk_ring_quiet:
		assert property (cfg_out.token_ring_disable && $past(cfg_out.token_ring_disable)
			|-> !token_out_pin)
		else $error("token with ring off");
	chk_irq_masked:
		assert property (cfg_out.clock_supervision_off && $past(cfg_out.clock_supervision_off)
			|-> !clock_loss_irq)
		else $error("masked clock loss");
	chk_second_sync_active_follow:
		assert property (sel_steady |-> cfg_out.second_sync_active == cfg_out.select_second_sync)
		else $error("pair lags request");
	chk_mbl_drive:
		assert property ($past(cfg_out.mem_bus_drive_idle) && !$past(device_reset_out)
			|-> !mem_bus_oe_n)
		else $error("bus released");
	chk_mbl_release:
		assert property (!$past(cfg_out.mem_bus_drive_idle) && !$past(mem_cycle_active)
			&& !$past(device_reset_out) |-> mem_bus_oe_n)
		else $error("bus driven idle");
	chk_sbw_pair:
		assert property (sbw_store.valid |-> $past(sbw_valid_in) && $past(cfg_out.six_bit_word_enable)
			&& sbw_store.word == $past(sbw_word_in) && sbw_store.channel == $past(sbw_chan_in))
		else $error("bad six-bit store");
endmodule : gccr_top_sva

// ---- gccr_ring_peer.sv ----
// Neighbour device model that hands the token back into the ring
module gccr_ring_peer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic token_out_pin,
	output logic token_in_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// Four-cycle pulse so the input filter of the device sees it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			token_in_pin <= 1'h0;
		end else if (token_out_pin) begin
			cnt <= slow ? 44 : 14;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			token_in_pin <= (cnt <= 4);
		end else begin
			token_in_pin <= 1'h0;
		end
	end
endmodule : gccr_ring_peer

// ---- tb_gccr_top.sv ----
// Self-checking testbench for the config registers
module tb_gccr_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_ID = gccr_pkg::ADDR_ID_AND_COMMAND;
	localparam logic [7:0] A_GCR = gccr_pkg::ADDR_GENERAL_CONFIG;
	localparam logic [7:0] A_TMR = gccr_pkg::ADDR_TIMER;
	logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h799148c8;
	logic [3:0] s_axi_wstrb = 4'h0, sbw_chan_in = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] sbw_word_in = 6'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_awready;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, token_in_pin, token_out_pin, mem_grant;
	logic mem_access_req = 1'h0, mem_access_done = 1'h0, mem_cycle_active = 1'h0;
	logic clock_a_pin = 1'h0, clock_b_pin = 1'h0, vcxo_ref_tick = 1'h0, sbw_valid_in = 1'h0;
	logic tx_hdlc_bit = 1'h0, serial_input_seven = 1'h0, mem_bus_oe_n, watchdog_alarm_out;
	logic clock_loss_irq, data_clock_out, vcxo_sync_pulse, matrix_in_seven, sbw_irq;
	logic device_reset_out;
	gccr_pkg::gccr_sbw_t sbw_store;
	gccr_pkg::gccr_cfg_t cfg_out;
	logic [15:0] gcr_m = 16'h0000, timer_m = gccr_pkg::TIMER_RESET;
	int fail_count = 0, num_checks = 0, tok_cnt = 0;

	always #2 aclk = ~aclk;

	gccr_top #(.QUARTER_SEC_CYCLES(20)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .token_in_pin, .token_out_pin, .mem_access_req,
		.mem_access_done, .mem_grant, .mem_cycle_active, .mem_bus_oe_n, .watchdog_alarm_out,
		.clock_a_pin, .clock_b_pin, .clock_loss_irq, .data_clock_out, .vcxo_ref_tick,
		.vcxo_sync_pulse, .tx_hdlc_bit, .serial_input_seven, .matrix_in_seven, .sbw_word_in,
		.sbw_chan_in, .sbw_valid_in, .sbw_store, .sbw_irq, .cfg_out, .device_reset_out);
	gccr_ring_peer u_peer (.aclk, .aresetn, .slow, .token_out_pin, .token_in_pin);

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	// Tiny word space so identical six-bit words repeat often
	always @(posedge aclk) begin
		rnd <= lfsr_next(rnd);
		vcxo_ref_tick <= rnd[3];
		clock_a_pin <= ~clock_a_pin;
		clock_b_pin <= rnd[4];
		sbw_valid_in <= rnd[5];
		sbw_word_in <= {5'h00, rnd[6]};
		sbw_chan_in <= {3'h0, rnd[7]};
		mem_cycle_active <= mem_grant & mem_access_req;
		if (token_out_pin)
			tok_cnt <= tok_cnt + 1;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t pin %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case (a)
			A_ID: return {16'h0000, gccr_pkg::ID_TYPE, gccr_pkg::ID_FOUNDRY,
				gccr_pkg::ID_REVISION, gccr_pkg::ID_VERSION};
			A_GCR: return {16'h0000, gcr_m[15:12], gcr_m[10], gcr_m[10:0]};
			A_TMR: return {16'h0000, timer_m};
			default: return 32'h0;
		endcase
	endfunction : exp_rd

	function automatic logic [31:0] exp_resp(input logic [7:0] a);
		return {30'h0, (a inside {A_ID, A_GCR, A_TMR, gccr_pkg::ADDR_STAMP, gccr_pkg::ADDR_STATUS,
			gccr_pkg::ADDR_SBW_MASK}) ? gccr_pkg::RESP_OKAY : gccr_pkg::RESP_SLVERR};
	endfunction : exp_resp

	// Both channels offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic aw_busy = 1'h1, w_busy = 1'h1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw_busy || w_busy || !s_axi_bvalid) begin
			@(posedge aclk);
			if (aw_busy && s_axi_awready) begin
				aw_busy = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w_busy && s_axi_wready) begin
				w_busy = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		s_axi_bready <= 1'h0;
		check_word({30'h0, s_axi_bresp}, exp_resp(a));
		if (a == A_GCR)
			gcr_m = d;
		if (a == A_TMR)
			timer_m = d;
		if (a == A_ID && d[gccr_pkg::CMD_SOFT_RESET]) begin
			gcr_m = gccr_pkg::GCR_RESET;
			timer_m = gccr_pkg::TIMER_RESET;
			repeat (2) @(posedge aclk);
		end
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		check_word(s_axi_rdata, exp_rd(a));
		check_word({30'h0, s_axi_rresp}, exp_resp(a));
	endtask : rd_chk

	task automatic done_pulse();
		mem_access_done <= 1'h1;
		@(posedge aclk);
		mem_access_done <= 1'h0;
		repeat (8) @(posedge aclk);
	endtask : done_pulse

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	initial begin
		int t, n;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd_chk(A_ID);
		rd_chk(A_GCR);
		rd_chk(8'h04);
		wr(8'h04, 16'hffff);
		repeat (6) begin
			wr(A_GCR, rnd[15:0]);
			rd_chk(A_GCR);
		end
		wr(A_TMR, 16'h0005);
		wr(A_ID, 16'h0004);
		rd_chk(A_GCR);
		rd_chk(A_TMR);
		rd_chk(A_ID);
		$display("test registers done");
		t = tok_cnt;
		wr(A_ID, 16'h0001);
		repeat (30) @(posedge aclk);
		check_word(32'(tok_cnt - t), 32'h1);
		mem_access_req <= 1'h1;
		slow <= 1'h1;
		repeat (3) @(posedge aclk);
		check_bit(mem_grant, 1'h1);
		done_pulse();
		check_word(32'(tok_cnt - t), 32'h2);
		check_bit(mem_grant, 1'h0);
		wr(A_GCR, 16'h0002);
		repeat (60) @(posedge aclk);
		check_bit(mem_grant, 1'h1);
		done_pulse();
		check_word(32'(tok_cnt - t), 32'h2);
		check_bit(mem_grant, 1'h1);
		wr(A_GCR, 16'h0006);
		wr(A_ID, 16'h0001);
		repeat (20) @(posedge aclk);
		check_bit(mem_grant, 1'h0);
		check_word(32'(tok_cnt - t), 32'h2);
		mem_access_req <= 1'h0;
		$display("test token done");
		wr(A_TMR, 16'h0003);
		repeat (3) begin
			wr(A_ID, 16'h0002);
			repeat (30) @(posedge aclk);
			check_bit(watchdog_alarm_out, 1'h0);
		end
		n = 0;
		while (!watchdog_alarm_out && n < 100) begin
			@(posedge aclk);
			n++;
		end
		check_bit(watchdog_alarm_out, 1'h1);
		wr(A_GCR, 16'h0007);
		repeat (40) @(posedge aclk);
		check_bit(watchdog_alarm_out, 1'h0);
		$display("test watchdog done");
		for (int i = 0; i < 4; i++) begin
			wr(A_GCR, {10'h000, i[0], 5'h00});
			tx_hdlc_bit <= rnd[0];
			serial_input_seven <= rnd[1];
			repeat (8) @(posedge aclk);
			check_bit(matrix_in_seven, i[0] ? tx_hdlc_bit : serial_input_seven);
		end
		$display("test matrix done");
		final_report();
	end
endmodule : tb_gccr_top

bind gccr_top gccr_top_sva u_sva (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .token_out_pin, .mem_access_req, .mem_grant, .mem_cycle_active,
	.mem_bus_oe_n, .watchdog_alarm_out, .clock_loss_irq, .sbw_word_in, .sbw_chan_in,
	.sbw_valid_in, .sbw_store, .cfg_out, .device_reset_out);
